//--- core/lfcs_regs.vh
// constants of the lock and configuration store
// assumes a single clock domain, included by bare name
`ifndef LFCS_REGS_VH
`define LFCS_REGS_VH
// read spaces of the programmer port
`define LFCS_SP_SIG        3'h0
`define LFCS_SP_TRIM       3'h1
`define LFCS_SP_PROT       3'h2
`define LFCS_SP_EXT        3'h3
`define LFCS_SP_HIGH       3'h4
`define LFCS_SP_LOW        3'h5
// signature space offsets
`define LFCS_SIG_OFS0      2'h0
`define LFCS_SIG_OFS1      2'h1
`define LFCS_SIG_OFS2      2'h2
// reset values, 1 = unprogrammed
`define LFCS_PROT_RST      2'h3
`define LFCS_EXT_RST       8'hFF
`define LFCS_HIGH_RST      8'hDF
`define LFCS_LOW_RST       8'h62
// field positions
`define LFCS_EXT_SELFWR    0
`define LFCS_HI_RSTDIS     7
`define LFCS_HI_DBG        6
`define LFCS_HI_SERDL      5
`define LFCS_HI_WDT        4
`define LFCS_HI_EEKEEP     3
`define LFCS_LO_DIV8       7
`define LFCS_LO_CLOCK_OUTPUT_FUSE      6
// clock source code of the internal rc at 8.0 MHz
`define LFCS_CKSRC_RC8     4'h2
// software pointer values
`define LFCS_PTR_LOW       16'h0000
`define LFCS_PTR_PROT      16'h0001
`define LFCS_PTR_EXT       16'h0002
`define LFCS_PTR_HIGH      16'h0003
// cycles in which a load must follow the flag set
`define LFCS_SW_WINDOW     2'h3
`endif

//--- core/lfcs_top.v
// lock bit and configuration byte store with boot latching
// assumes rst_i is the power-on reset and all inputs are synchronous
//
// Summary of operation
// - two protection bits, 1 unprogrammed, 0 programmed
// - only chip erase or rst_i returns protection bits to 1
// - debug fuse programmed allows debug memory readout
// - mode 1, both bits 1, no restrictions
// - mode 2 blocks programming, locks fuses, debug
// - mode 3 also blocks verification readout
// - three fuse bytes, programmed reads 0
// - extended bit 0 self-write enable, others 1
// - high byte reset, debug, watchdog, brownout fields
// - high bit 3 keeps eeprom through erase
// - high bit 5 serial download, fixed in serial
// - low byte divider, clock out, startup, source
// - clock output fuse drives clock on pin
// - default source selects internal rc 8 MHz
// - chip erase leaves all fuses unchanged
// - protection bit a programmed refuses fuse changes
// - fuses latched on programming entry and exit, applied after
// - eeprom keep fuse acts immediately, unlatched
// - fuses also latched at power-up
// - three signature bytes readable even when locked
// - trim byte copied to oscillator register on the first edge after reset
// - software reads low, protection, high by pointer
`timescale 1ns/1ns
`include "lfcs_regs.vh"
module lfcs_top #(
   parameter [7:0] SIG_BYTE0 = 8'h5A, // arbitrary value
   parameter [7:0] SIG_BYTE1 = 8'hA5, // arbitrary value
   parameter [7:0] SIG_BYTE2 = 8'h3C, // arbitrary value
   parameter [7:0] TRIM_BYTE = 8'h80  // arbitrary value
) (
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        prog_mode_i,
   input  wire        prog_hv_i,
   input  wire        chip_erase_i,
   input  wire        wr_prot_i,
   input  wire        wr_ext_i,
   input  wire        wr_high_i,
   input  wire        wr_low_i,
   input  wire [7:0]  wr_data_i,
   input  wire        rd_req_i,
   input  wire [2:0]  rd_space_i,
   input  wire [1:0]  rd_addr_i,
   input  wire        sw_flag_set_i,
   input  wire        sw_load_i,
   input  wire [15:0] sw_ptr_i,
   output reg  [7:0]  rd_data_o,
   output reg         rd_valid_o,
   output reg         rd_refused_o,
   output reg  [7:0]  sw_data_o,
   output reg         sw_valid_o,
   output reg         read_config_bits_flag_o,
   output reg         store_enable_flag_o,
   output reg  [1:0]  prot_mode_o,
   output reg         mem_write_block_o,
   output reg         mem_verify_block_o,
   output reg         fuse_lock_o,
   output reg         debug_link_en_o,
   output reg         debug_readout_ok_o,
   output reg         eeprom_erase_o,
   output reg         eeprom_preserve_o,
   output reg         self_write_en_o,
   output reg         ext_reset_disable_o,
   output reg         serial_download_en_o,
   output reg         watchdog_forced_on_o,
   output reg  [2:0]  brownout_level_o,
   output reg         clock_div_eight_o,
   output reg         port_b_pin_four_clk_en_o,
   output reg  [1:0]  startup_time_sel_o,
   output reg  [3:0]  clock_source_sel_o,
   output reg         internal_rc_sel_o,
   output reg  [7:0]  oscillator_trim_register_o
);

   // stored bits, nonvolatile in the real part
   reg  [1:0] prot;
   reg  [7:0] ext_cfg;
   reg  [7:0] high_cfg;
   reg  [7:0] low_cfg;
   // latched copies that steer the device
   reg  [7:0] ext_lat;
   reg  [7:0] high_lat;
   reg  [7:0] low_lat;
   reg        boot_done;
   reg        prog_mode_q;
   reg  [1:0] sw_cnt;
   reg  [1:0] next_prot;
   reg  [7:0] next_high;
   reg  [7:0] rd_mux;
   reg        rd_ok;
   reg  [7:0] sw_mux;
   reg        sw_hit;

   wire       fuses_open;
   wire       latch_now;
   wire       prot_a_prog;
   wire       unrestricted;
   wire       verify_lock;

   // protection bit a is bit 0, bit b is bit 1
   assign prot_a_prog  = ~prot[0];
   assign unrestricted = (prot == `LFCS_PROT_RST);
   assign verify_lock  = (prot == 2'b00);
   // any programmed bit locks fuses
   assign fuses_open   = unrestricted & ~prot_a_prog;
   // latch at boot and on both edges of programming mode
   assign latch_now    = ~boot_done | (prog_mode_i ^ prog_mode_q);

   // protection bits only ever go 1 to 0 by writing
   always @* begin
      next_prot = prot;
      if (prog_mode_i && chip_erase_i) begin
         next_prot = `LFCS_PROT_RST;
      end else if (prog_mode_i && wr_prot_i) begin
         next_prot = prot & wr_data_i[1:0];
      end
   end

   // serial mode cannot alter the serial download fuse
   always @* begin
      next_high = wr_data_i;
      if (!prog_hv_i) begin
         next_high[`LFCS_HI_SERDL] = high_cfg[`LFCS_HI_SERDL];
      end
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         prot     <= `LFCS_PROT_RST;
         ext_cfg  <= `LFCS_EXT_RST;
         high_cfg <= `LFCS_HIGH_RST;
         low_cfg  <= `LFCS_LOW_RST;
      end else begin
         prot <= next_prot;
         // chip erase leaves fuses alone
         if (prog_mode_i && fuses_open && !chip_erase_i) begin
            if (wr_ext_i) begin
               // unused bits stay 1
               ext_cfg <= {7'h7F, wr_data_i[`LFCS_EXT_SELFWR]};
            end
            if (wr_high_i) begin
               high_cfg <= next_high;
            end
            if (wr_low_i) begin
               low_cfg <= wr_data_i;
            end
         end
      end
   end

   // latched fuse copies; writes in a session wait for the exit
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_lat     <= `LFCS_EXT_RST;
         high_lat    <= `LFCS_HIGH_RST;
         low_lat     <= `LFCS_LOW_RST;
         boot_done   <= 1'b0;
         prog_mode_q <= 1'b0;
      end else begin
         boot_done   <= 1'b1;
         prog_mode_q <= prog_mode_i;
         if (latch_now) begin
            ext_lat  <= ext_cfg;
            high_lat <= high_cfg;
            low_lat  <= low_cfg;
         end
      end
   end

   // the trim copy lands on the first edge after release
   // because an async reset may only load constants
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         oscillator_trim_register_o <= 8'h00;
      end else begin
         if (!boot_done) begin
            oscillator_trim_register_o <= TRIM_BYTE;
         end
      end
   end

   // programmer reads; signature and trim ignore protection
   always @* begin
      rd_mux = 8'hFF;
      rd_ok  = 1'b1;
      case (rd_space_i)
         `LFCS_SP_SIG: begin
            case (rd_addr_i)
               `LFCS_SIG_OFS0: rd_mux = SIG_BYTE0;
               `LFCS_SIG_OFS1: rd_mux = SIG_BYTE1;
               `LFCS_SIG_OFS2: rd_mux = SIG_BYTE2;
               default:        rd_ok  = 1'b0;
            endcase
         end
         `LFCS_SP_TRIM: begin
            rd_mux = TRIM_BYTE;
         end
         `LFCS_SP_PROT: begin
            rd_mux = {6'h3F, prot};
         end
         `LFCS_SP_EXT: begin
            rd_mux = ext_cfg;
         end
         `LFCS_SP_HIGH: begin
            rd_mux = high_cfg;
         end
         `LFCS_SP_LOW: begin
            rd_mux = low_cfg;
         end
         default: begin
            rd_ok  = 1'b0;
         end
      endcase
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o    <= 8'h00;
         rd_valid_o   <= 1'b0;
         rd_refused_o <= 1'b0;
      end else begin
         rd_valid_o   <= rd_req_i & prog_mode_i & rd_ok;
         rd_refused_o <= rd_req_i & ~(prog_mode_i & rd_ok);
         if (rd_req_i && prog_mode_i && rd_ok) begin
            rd_data_o <= rd_mux;
         end
      end
   end

   // software readout by pointer
   always @* begin
      sw_mux = 8'hFF;
      sw_hit = 1'b1;
      case (sw_ptr_i)
         `LFCS_PTR_LOW: begin
            sw_mux = low_cfg;
         end
         `LFCS_PTR_PROT: begin
            sw_mux = {6'h3F, prot};
         end
         `LFCS_PTR_EXT: begin
            sw_mux = ext_cfg;
         end
         `LFCS_PTR_HIGH: begin
            sw_mux = high_cfg;
         end
         default: begin
            sw_hit = 1'b0;
         end
      endcase
   end

   // flags run a three cycle window, then clear themselves
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sw_cnt     <= 2'h0;
         sw_data_o  <= 8'h00;
         sw_valid_o <= 1'b0;
         read_config_bits_flag_o <= 1'b0;
         store_enable_flag_o     <= 1'b0;
      end else begin
         sw_valid_o <= 1'b0;
         if (sw_flag_set_i) begin
            sw_cnt <= `LFCS_SW_WINDOW;
            read_config_bits_flag_o <= 1'b1;
            store_enable_flag_o     <= 1'b1;
         end else if (sw_cnt != 2'h0) begin
            if (sw_load_i && sw_hit) begin
               sw_data_o  <= sw_mux;
               sw_valid_o <= 1'b1;
               sw_cnt     <= 2'h0;
               read_config_bits_flag_o <= 1'b0;
               store_enable_flag_o     <= 1'b0;
            end else if (sw_cnt == 2'h1) begin
               sw_cnt <= 2'h0;
               read_config_bits_flag_o <= 1'b0;
               store_enable_flag_o     <= 1'b0;
            end else begin
               sw_cnt <= sw_cnt - 2'h1;
            end
         end
      end
   end

   // protection decode, taken live from the stored bits
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         prot_mode_o          <= 2'h1;
         mem_write_block_o    <= 1'b0;
         mem_verify_block_o   <= 1'b0;
         fuse_lock_o          <= 1'b0;
      end else begin
         // mode 2 also covers the unlisted combination
         if (unrestricted) begin
            prot_mode_o <= 2'h1;
         end else if (verify_lock) begin
            prot_mode_o <= 2'h3;
         end else begin
            prot_mode_o <= 2'h2;
         end
         mem_write_block_o  <= ~unrestricted;
         mem_verify_block_o <= verify_lock;
         fuse_lock_o        <= ~fuses_open;
      end
   end

   // debug link and eeprom controls
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         debug_link_en_o      <= 1'b0;
         debug_readout_ok_o   <= 1'b0;
         eeprom_erase_o       <= 1'b0;
         eeprom_preserve_o    <= 1'b0;
      end else begin
         // locking disables the link itself
         debug_link_en_o <= unrestricted & ~high_lat[`LFCS_HI_DBG];
         // readout stays open while the fuse is programmed
         debug_readout_ok_o <= ~high_lat[`LFCS_HI_DBG];
         // the keep fuse is taken live, not latched
         eeprom_preserve_o <= ~high_cfg[`LFCS_HI_EEKEEP];
         eeprom_erase_o <= prog_mode_i & chip_erase_i &
                           high_cfg[`LFCS_HI_EEKEEP];
      end
   end

   // latched extended and high byte fuses
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         self_write_en_o      <= 1'b0;
         ext_reset_disable_o  <= 1'b0;
         serial_download_en_o <= 1'b1;
         watchdog_forced_on_o <= 1'b0;
         brownout_level_o     <= 3'h7;
      end else begin
         self_write_en_o      <= ~ext_lat[`LFCS_EXT_SELFWR];
         ext_reset_disable_o  <= ~high_lat[`LFCS_HI_RSTDIS];
         serial_download_en_o <= ~high_lat[`LFCS_HI_SERDL];
         watchdog_forced_on_o <= ~high_lat[`LFCS_HI_WDT];
         brownout_level_o     <= high_lat[2:0];
      end
   end

   // latched low byte clock fuses
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         clock_div_eight_o    <= 1'b1;
         port_b_pin_four_clk_en_o <= 1'b0;
         startup_time_sel_o   <= 2'h2;
         clock_source_sel_o   <= `LFCS_CKSRC_RC8;
         internal_rc_sel_o    <= 1'b1;
      end else begin
         clock_div_eight_o    <= ~low_lat[`LFCS_LO_DIV8];
         port_b_pin_four_clk_en_o <= ~low_lat[`LFCS_LO_CLOCK_OUTPUT_FUSE];
         startup_time_sel_o   <= low_lat[5:4];
         clock_source_sel_o   <= low_lat[3:0];
         internal_rc_sel_o    <= (low_lat[3:0] == `LFCS_CKSRC_RC8);
      end
   end

endmodule

//--- sim/lfcs_sva.sv
// assertions on the ports of the lock and configuration store
// assumes one clock domain and a bind onto the store's top module
`timescale 1ns/1ns
module lfcs_sva #(
   parameter [7:0] TRIM_BYTE = 8'h80
) (
   input wire        mclk_i,
   input wire        rst_i,
   input wire        prog_mode_i,
   input wire        chip_erase_i,
   input wire        rd_req_i,
   input wire [2:0]  rd_space_i,
   input wire [1:0]  rd_addr_i,
   input wire        sw_flag_set_i,
   input wire        sw_load_i,
   input wire [15:0] sw_ptr_i,
   input wire        rd_valid_o,
   input wire        rd_refused_o,
   input wire        sw_valid_o,
   input wire        read_config_bits_flag_o,
   input wire [1:0]  prot_mode_o,
   input wire        mem_write_block_o,
   input wire        mem_verify_block_o,
   input wire        fuse_lock_o,
   input wire        debug_link_en_o,
   input wire        eeprom_erase_o,
   input wire [3:0]  clock_source_sel_o,
   input wire        internal_rc_sel_o,
   input wire [7:0]  oscillator_trim_register_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   // a window runs out if no load and no new set arrives
   sequence sw_open;
      sw_flag_set_i ##1 (!sw_load_i && !sw_flag_set_i) [*3];
   endsequence
   sequence sw_hit;
      sw_flag_set_i ##1 (sw_load_i && sw_ptr_i <= 16'h0003);
   endsequence
   a_read_one_answer: assert property (rd_req_i |=> rd_valid_o != rd_refused_o)
      else $error("read request without exactly one answer");
   a_read_idle_quiet: assert property (!rd_req_i |=> !rd_valid_o && !rd_refused_o)
      else $error("read answer without request");
   a_sig_always_served: assert property (rd_req_i && prog_mode_i && rd_space_i == 3'h0
      && rd_addr_i != 2'h3 |=> rd_valid_o) else $error("signature read refused");
   a_mode_two_locks: assert property (prot_mode_o == 2'h2 |-> mem_write_block_o
      && !mem_verify_block_o && fuse_lock_o && !debug_link_en_o) else $error("mode 2 decode");
   a_mode_three_locks: assert property (prot_mode_o == 2'h3 |-> mem_write_block_o
      && mem_verify_block_o && fuse_lock_o && !debug_link_en_o) else $error("mode 3 decode");
   a_mode_one_free: assert property (prot_mode_o == 2'h1 |-> !mem_write_block_o
      && !mem_verify_block_o && !fuse_lock_o) else $error("mode 1 decode");
   a_rc_source_decode: assert property (internal_rc_sel_o == (clock_source_sel_o == 4'h2))
      else $error("internal rc select wrong");
   a_erase_has_cause: assert property (eeprom_erase_o |-> $past(chip_erase_i) && $past(prog_mode_i))
      else $error("eeprom erase without chip erase");
   a_trim_loaded: assert property (!$past(rst_i) |-> oscillator_trim_register_o == TRIM_BYTE)
      else $error("trim register not loaded");
   a_sw_window_close: assert property (sw_open |=> !read_config_bits_flag_o)
      else $error("read flag outlives window");
   a_sw_hit_answer: assert property (sw_hit |=> sw_valid_o)
      else $error("software load in window not answered");
endmodule

//--- sim/lfcs_prog_model.sv
// programmer model: drives the programming port of the store
// assumes the store's clock; tasks start just after a rising edge
`timescale 1ns/1ns
module lfcs_prog_model (
   input  wire       clk_i,
   input  wire       rd_valid_i,
   input  wire [7:0] rd_data_i,
   output reg        prog_mode_o,
   output reg        prog_hv_o,
   output reg        erase_o,
   output reg  [3:0] wr_o,
   output reg  [7:0] wr_data_o,
   output reg        rd_req_o,
   output reg  [2:0] rd_space_o,
   output reg  [1:0] rd_addr_o
);
   initial begin
      prog_mode_o = 1'b0;
      prog_hv_o = 1'b0;
      erase_o = 1'b0;
      wr_o = 4'h0;
      wr_data_o = 8'hA5;
      rd_req_o = 1'b0;
      rd_space_o = 3'h7;
      rd_addr_o = 2'h3;
   end
   // high voltage select is driven from hv on every call, with the mode
   task session(input logic on, input logic hv);
      @(posedge clk_i);
      prog_mode_o <= on;
      prog_hv_o <= hv;
   endtask
   // sel bits: 0 protection, 1 extended, 2 high, 3 low
   task wr(input logic [3:0] sel, input logic [7:0] d);
      @(posedge clk_i);
      wr_o <= sel;
      wr_data_o <= d;
      @(posedge clk_i);
      wr_o <= 4'h0;
      wr_data_o <= ~d;
   endtask
   task erase;
      @(posedge clk_i);
      erase_o <= 1'b1;
      @(posedge clk_i);
      erase_o <= 1'b0;
      #1;
   endtask
   task rd(input logic [2:0] sp, input logic [1:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_i);
      rd_req_o <= 1'b1;
      rd_space_o <= sp;
      rd_addr_o <= a;
      @(posedge clk_i);
      rd_req_o <= 1'b0;
      rd_space_o <= ~sp;
      rd_addr_o <= ~a;
      #1;
      v = rd_valid_i;
      d = rd_data_i;
   endtask
endmodule

//--- sim/lfcs_top_bench.sv
// bench of the lock and configuration store with a programmer model
// assumes the store's read space codes; signature values are arbitrary
`timescale 1ns/1ns
`include "lfcs_regs.vh"
module lfcs_top_bench;
   localparam logic [7:0] SIG [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   logic mclk_i = 1'b0, rst_i = 1'b1, sw_flag_set_i = 1'b0, sw_load_i = 1'b0;
   logic [15:0] sw_ptr_i = 16'h0000;
   wire prog_mode_i, prog_hv_i, chip_erase_i, wr_prot_i, wr_ext_i, wr_high_i, wr_low_i;
   wire rd_req_i, rd_valid_o, rd_refused_o, sw_valid_o, read_config_bits_flag_o;
   wire store_enable_flag_o, mem_write_block_o, mem_verify_block_o, fuse_lock_o;
   wire debug_link_en_o, debug_readout_ok_o, eeprom_erase_o, eeprom_preserve_o;
   wire self_write_en_o, ext_reset_disable_o, serial_download_en_o, watchdog_forced_on_o;
   wire clock_div_eight_o, port_b_pin_four_clk_en_o, internal_rc_sel_o;
   wire [7:0] wr_data_i, rd_data_o, sw_data_o, oscillator_trim_register_o;
   wire [2:0] rd_space_i, brownout_level_o;
   wire [1:0] rd_addr_i, prot_mode_o, startup_time_sel_o;
   wire [3:0] clock_source_sel_o;
   int mismatches = 0;
   int cmp_count = 0;
   always #4 mclk_i = ~mclk_i;
   lfcs_top #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .TRIM_BYTE(SIG[3]))
      dut (.*);
   lfcs_prog_model m (.clk_i(mclk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
      .prog_mode_o(prog_mode_i), .prog_hv_o(prog_hv_i), .erase_o(chip_erase_i),
      .wr_o({wr_low_i, wr_high_i, wr_ext_i, wr_prot_i}), .wr_data_o(wr_data_i),
      .rd_req_o(rd_req_i), .rd_space_o(rd_space_i), .rd_addr_o(rd_addr_i));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chkb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task rdc(input logic [2:0] sp, input logic [1:0] a, input logic [7:0] exp, input logic ok);
      logic [7:0] d;
      logic       v;
      m.rd(sp, a, d, v);
      chkb(v, ok);
      chkb(rd_refused_o, !ok);
      if (ok) chk(d, exp);
   endtask
   // gap = idle edges between the flag set and the load
   task swr(input logic [15:0] p, input int gap, input logic [7:0] exp, input logic ok);
      @(posedge mclk_i);
      sw_flag_set_i <= 1'b1;
      @(posedge mclk_i);
      sw_flag_set_i <= 1'b0;
      repeat (gap) @(posedge mclk_i);
      sw_load_i <= 1'b1;
      sw_ptr_i <= p;
      @(posedge mclk_i);
      sw_load_i <= 1'b0;
      sw_ptr_i <= ~p;
      #1;
      chkb(store_enable_flag_o, 1'b0);
      chkb(read_config_bits_flag_o, 1'b0);
      chkb(sw_valid_o, ok);
      if (ok) chk(sw_data_o, exp);
   endtask
   task settle;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk(oscillator_trim_register_o, SIG[3]);
      chkb(internal_rc_sel_o, 1'b1);
      rdc(`LFCS_SP_SIG, 2'h0, 8'h00, 1'b0);
      m.session(1'b1, 1'b1);
      for (int i = 0; i < 4; i++) rdc(i == 3 ? `LFCS_SP_TRIM : `LFCS_SP_SIG, i[1:0], SIG[i], 1'b1);
      rdc(`LFCS_SP_PROT, 2'h0, 8'hFF, 1'b1);
      rdc(`LFCS_SP_EXT, 2'h0, 8'hFF, 1'b1);
      rdc(`LFCS_SP_HIGH, 2'h0, 8'hDF, 1'b1);
      rdc(`LFCS_SP_LOW, 2'h0, 8'h62, 1'b1);
      rdc(`LFCS_SP_SIG, 2'h3, 8'h00, 1'b0);
      rdc(3'h6, 2'h0, 8'h00, 1'b0);
      m.wr(4'h8, 8'h22); // fuses before protection
      rdc(`LFCS_SP_LOW, 2'h0, 8'h22, 1'b1);
      m.wr(4'h2, 8'h00);
      rdc(`LFCS_SP_EXT, 2'h0, 8'hFE, 1'b1);
      m.session(1'b1, 1'b0);
      m.wr(4'h4, 8'hF7);
      rdc(`LFCS_SP_HIGH, 2'h0, 8'hD7, 1'b1);
      chkb(eeprom_preserve_o, 1'b1);
      chkb(port_b_pin_four_clk_en_o, 1'b0);
      m.erase();
      chkb(eeprom_erase_o, 1'b0);
      m.session(1'b1, 1'b1);
      m.wr(4'h4, 8'hBF);
      m.erase();
      chkb(eeprom_erase_o, 1'b1);
      rdc(`LFCS_SP_HIGH, 2'h0, 8'hBF, 1'b1);
      m.session(1'b0, 1'b1);
      settle;
      chkb(port_b_pin_four_clk_en_o, 1'b1);
      chkb(self_write_en_o, 1'b1);
      chkb(serial_download_en_o, 1'b0);
      chkb(watchdog_forced_on_o, 1'b0);
      chkb(ext_reset_disable_o, 1'b0);
      chk({5'h00, brownout_level_o}, 8'h07);
      chkb(clock_div_eight_o, 1'b1);
      chk({6'h00, startup_time_sel_o}, 8'h02);
      chk({4'h0, clock_source_sel_o}, 8'h02);
      chkb(debug_link_en_o, 1'b1);
      m.session(1'b1, 1'b1);
      m.wr(4'h1, 8'hFD);
      settle;
      chk({6'h00, prot_mode_o}, 8'h02);
      chkb(mem_write_block_o, 1'b1);
      m.wr(4'h1, 8'hFE);
      rdc(`LFCS_SP_PROT, 2'h0, 8'hFC, 1'b1);
      chk({6'h00, prot_mode_o}, 8'h03);
      chkb(mem_verify_block_o, 1'b1);
      chkb(fuse_lock_o, 1'b1);
      chkb(debug_link_en_o, 1'b0);
      m.wr(4'h8, 8'hFF);
      rdc(`LFCS_SP_LOW, 2'h0, 8'h22, 1'b1);
      rdc(`LFCS_SP_SIG, 2'h1, SIG[1], 1'b1);
      m.wr(4'h1, 8'hFF);
      rdc(`LFCS_SP_PROT, 2'h0, 8'hFC, 1'b1);
      m.session(1'b0, 1'b1);
      settle;
      chkb(debug_readout_ok_o, 1'b1);
      swr(16'h0001, 0, 8'hFC, 1'b1);
      swr(16'h0003, 2, 8'hBF, 1'b1);
      swr(16'h0000, 1, 8'h22, 1'b1);
      swr(16'h0003, 3, 8'h00, 1'b0);
      m.session(1'b1, 1'b1);
      m.erase();
      rdc(`LFCS_SP_PROT, 2'h0, 8'hFF, 1'b1);
      chk({6'h00, prot_mode_o}, 8'h01);
      end_sim;
   end
endmodule
bind lfcs_top lfcs_sva #(.TRIM_BYTE(TRIM_BYTE)) u_sva (.*);
